// ---- inc/cs_pkg.sv ----
`default_nettype none
package cs_pkg;
  // Clock and time base
  localparam int CLK_NS    = 50;
  localparam int TICK_NS   = 100000;                          // 0.1 ms timer tick
  localparam int TICK_CYC  = TICK_NS / CLK_NS;
  localparam int FILT_NS   = 16000;                           // wake filter window, 16 us
  localparam int FILT_CYC  = (FILT_NS + CLK_NS - 1) / CLK_NS;

  // Register offsets
  localparam logic [7:0] REG_T1_SETUP  = 8'h00;
  localparam logic [7:0] REG_T2_SETUP  = 8'h01;
  localparam logic [7:0] REG_HS_A      = 8'h02;
  localparam logic [7:0] REG_HS_B      = 8'h03;
  localparam logic [7:0] REG_WAKE_EN   = 8'h04;
  localparam logic [7:0] REG_WSTAT_A   = 8'h05;
  localparam logic [7:0] REG_WSTAT_B   = 8'h06;
  localparam logic [7:0] REG_LVL       = 8'h07;
  localparam logic [7:0] REG_FAULT     = 8'h08;

  // Field positions
  localparam int F_PER     = 0;   // timer setup [2:0] period
  localparam int F_ON      = 3;   // timer setup [5:3] on-time
  localparam int F_TWAKE   = 0;   // wake enable [1:0] timer wake sources
  localparam int F_SENSE   = 2;   // wake enable [4:2] cyclic sense per pin
  localparam int F_TSEL    = 5;   // wake enable [7:5] timer select per pin
  localparam int F_CMDERR  = 0;   // fault [0] command error
  localparam int F_UVEN    = 1;   // fault [1] undervoltage switch-off enable
  localparam int F_OVEN    = 2;   // fault [2] overvoltage switch-off enable
  localparam int F_HSOFF   = 4;   // fault [7:4] outputs switched off by fault

  // Reset values
  localparam logic [5:0] RST_SETUP = 6'h00;
  localparam logic [3:0] RST_HS    = 4'h0;
  localparam logic [7:0] RST_WEN   = 8'h00;

  // On-time codes
  localparam logic [2:0] ON_OFF_LOW  = 3'h0;
  localparam logic [2:0] ON_0P1      = 3'h1;
  localparam logic [2:0] ON_20MS     = 3'h5;
  localparam logic [2:0] ON_OFF_HIGH = 3'h6;

  // High-side mapping codes
  localparam logic [1:0] HS_OFF = 2'h0;
  localparam logic [1:0] HS_ON  = 2'h1;
  localparam logic [1:0] HS_T1  = 2'h2;
  localparam logic [1:0] HS_T2  = 2'h3;

  // Device modes seen on the mode input
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_STOP   = 2'h1;
  localparam logic [1:0] MODE_SLEEP  = 2'h2;
  localparam logic [1:0] MODE_FSAFE  = 2'h3;

  // Period in ticks: 10, 20, 50, 100, 200 ms, 1 s, 2 s; code 7 as 2 s
  function automatic logic [14:0] period_ticks(input logic [2:0] sel);
    case (sel)
      3'h0:    period_ticks = 15'd100;
      3'h1:    period_ticks = 15'd200;
      3'h2:    period_ticks = 15'd500;
      3'h3:    period_ticks = 15'd1000;
      3'h4:    period_ticks = 15'd2000;
      3'h5:    period_ticks = 15'd10000;
      default: period_ticks = 15'd20000;
    endcase
  endfunction

  // On-time in ticks: 0.1, 0.3, 1, 10, 20 ms; off settings give zero
  function automatic logic [14:0] on_ticks(input logic [2:0] sel);
    case (sel)
      3'h1:    on_ticks = 15'd1;
      3'h2:    on_ticks = 15'd3;
      3'h3:    on_ticks = 15'd10;
      3'h4:    on_ticks = 15'd100;
      3'h5:    on_ticks = 15'd200;
      default: on_ticks = 15'd0;
    endcase
  endfunction

  function automatic logic on_timed(input logic [2:0] sel);
    on_timed = (sel >= ON_0P1) && (sel <= ON_20MS);
  endfunction
endpackage
`default_nettype wire

// ---- inc/cs_timer_if.sv ----
`default_nettype none
interface cs_timer_if;
  logic [2:0] period_sel;
  logic [2:0] on_sel;
  logic       restart;   // one-cycle pulse after the setup is written
  logic       active;    // on-time in progress
  logic       on_start;  // pulse at each on-time start
  logic       on_end;    // pulse at each on-time end
  logic       first;     // current on-time is the first since start
  modport timer (input period_sel, on_sel, restart, output active, on_start, on_end, first);
  modport ctrl  (output period_sel, on_sel, restart, input active, on_start, on_end, first);
endinterface
`default_nettype wire

// ---- rtl/cs_timer.sv ----
`default_nettype none
module cs_timer #(
  parameter int TICK_CYCLES = cs_pkg::TICK_CYC
) (
  input  wire logic   clk,
  input  wire logic   rst,
  cs_timer_if.timer   tl
);
  logic [15:0] pre_r, pre_nxt;
  logic [14:0] cnt_r, cnt_nxt;
  logic        act_r, act_nxt;
  logic        st_r, st_nxt;
  logic        en_r, en_nxt;
  logic        first_r, first_nxt;
  logic        run;
  logic        tick;

  // Period counter in 0.1 ms ticks; the on-time opens each period
  always_comb
  begin
    run       = cs_pkg::on_timed(tl.on_sel);
    tick      = (pre_r == 16'(TICK_CYCLES - 1));
    pre_nxt   = tick ? 16'h0000 : pre_r + 16'h0001;
    cnt_nxt   = cnt_r;
    act_nxt   = act_r;
    st_nxt    = 1'b0;
    en_nxt    = 1'b0;
    first_nxt = first_r;
    if (!run)
    begin
      pre_nxt = 16'h0000;
      cnt_nxt = 15'h0000;
      act_nxt = 1'b0;
    end
    else if (tl.restart)
    begin
      // Starts on the on-time write alone, whatever is mapped
      pre_nxt   = 16'h0000;
      cnt_nxt   = 15'h0000;
      act_nxt   = 1'b1;
      st_nxt    = 1'b1;
      first_nxt = 1'b1;
    end
    else if (tick)
    begin
      if (cnt_r == cs_pkg::period_ticks(tl.period_sel) - 15'h0001)
      begin
        cnt_nxt   = 15'h0000;
        act_nxt   = 1'b1;
        st_nxt    = 1'b1;
        first_nxt = 1'b0;
      end
      else
      begin
        cnt_nxt = cnt_r + 15'h0001;
        if (cnt_r + 15'h0001 == cs_pkg::on_ticks(tl.on_sel))
        begin
          act_nxt = 1'b0;
          en_nxt  = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pre_r   <= 16'h0000;
      cnt_r   <= 15'h0000;
      act_r   <= 1'b0;
      st_r    <= 1'b0;
      en_r    <= 1'b0;
      first_r <= 1'b0;
    end
    else
    begin
      pre_r   <= pre_nxt;
      cnt_r   <= cnt_nxt;
      act_r   <= act_nxt;
      st_r    <= st_nxt;
      en_r    <= en_nxt;
      first_r <= first_nxt;
    end
  end

  assign tl.active   = act_r;
  assign tl.on_start = st_r;
  assign tl.on_end   = en_r;
  assign tl.first    = first_r;
endmodule
`default_nettype wire

// ---- rtl/cs_sampler.sv ----
`default_nettype none
module cs_sampler #(
  parameter int FILT_CYCLES = cs_pkg::FILT_CYC
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic armed,
  input  wire logic rearm,
  input  wire logic on_end,
  input  wire logic pin,
  output logic      valid,
  output logic      level,
  output logic      change
);
  typedef enum logic [1:0] {S_IDLE = 2'b01, S_FILT = 2'b10} samp_t;
  samp_t       st_r, st_nxt;
  logic [9:0]  cnt_r, cnt_nxt;
  logic        lvl0_r, lvl0_nxt;
  logic        stab_r, stab_nxt;
  logic        ref_r, ref_nxt;
  logic        have_r, have_nxt;
  logic        val_r, val_nxt;
  logic        lvl_r, lvl_nxt;
  logic        chg_r, chg_nxt;

  // Filter window opens on the on-time end; a stable level is compared to the last one
  always_comb
  begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    lvl0_nxt = lvl0_r;
    stab_nxt = stab_r;
    ref_nxt  = ref_r;
    have_nxt = have_r;
    val_nxt  = 1'b0;
    lvl_nxt  = lvl_r;
    chg_nxt  = 1'b0;
    case (st_r)
      S_IDLE:
      begin
        if (on_end && armed)
        begin
          st_nxt   = S_FILT;
          cnt_nxt  = 10'h000;
          lvl0_nxt = pin;
          stab_nxt = 1'b1;
        end
      end
      S_FILT:
      begin
        cnt_nxt  = cnt_r + 10'h001;
        stab_nxt = stab_r & (pin == lvl0_r);
        if (cnt_r == 10'(FILT_CYCLES - 1))
        begin
          st_nxt = S_IDLE;
          if (stab_r && (pin == lvl0_r))
          begin
            val_nxt  = 1'b1;
            lvl_nxt  = lvl0_r;
            chg_nxt  = have_r && (lvl0_r != ref_r);
            ref_nxt  = lvl0_r;
            have_nxt = 1'b1;
          end
        end
      end
      default:
        st_nxt = S_IDLE;
    endcase
    // A fresh start or loss of sensing forgets the reference
    if (!armed || rearm)
    begin
      have_nxt = 1'b0;
      if (!armed)
        st_nxt = S_IDLE;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_r   <= S_IDLE;
      cnt_r  <= 10'h000;
      lvl0_r <= 1'b0;
      stab_r <= 1'b0;
      ref_r  <= 1'b0;
      have_r <= 1'b0;
      val_r  <= 1'b0;
      lvl_r  <= 1'b0;
      chg_r  <= 1'b0;
    end
    else
    begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      lvl0_r <= lvl0_nxt;
      stab_r <= stab_nxt;
      ref_r  <= ref_nxt;
      have_r <= have_nxt;
      val_r  <= val_nxt;
      lvl_r  <= lvl_nxt;
      chg_r  <= chg_nxt;
    end
  end

  assign valid  = val_r;
  assign level  = lvl_r;
  assign change = chg_r;
endmodule
`default_nettype wire

// ---- rtl/cyclic_sense_wake_timers.sv ----
// Behaviour
// - A timer starts as soon as a timed on-time is written, mapping irrelevant.
// - Off-low and off-high settings fix a mapped output's level before sensing starts.
// - On-time longer than period sets the command error flag.
// - First sample is the reference; a later level difference causes wake or interrupt.
// - A 16 us stable-level filter starts at each on-time end.
// - A cyclic sense wake sets that pin's own wake event flag.
// - Level status takes sampled levels for sensed pins, raw levels otherwise, and only in Normal or Stop.
// - Cyclic sense wake interrupts in Stop, and requests regulator power-up in Sleep.
// - Fail-safe turns sensing outputs off and puts wake pins on static sensing.
// - Overcurrent, overtemperature, enabled under/overvoltage switch the output off.
// - Timers keep running when their output was switched off by a fault.
// - Any set wake flag while in Sleep requests an immediate wake.
// - A timer enabled as wake source interrupts periodically in Normal and Stop.
// - Cyclic wake interrupts at each on-time start except the first after start.
// - Each timer can be mapped to drive chosen high-side outputs.
// - Period choices are 10, 20, 50, 100, 200 ms, 1 s and 2 s.
// - On-time choices are 0.1, 0.3, 1, 10, 20 ms, or off high/low.
// - A level change seen in a sense on-time wakes or interrupts.
`default_nettype none
module cyclic_sense_wake_timers #(
  parameter int TICK_CYCLES = cs_pkg::TICK_CYC,
  parameter int FILT_CYCLES = cs_pkg::FILT_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  input  wire logic [1:0]  mode,
  input  wire logic [2:0]  wake_input_pin,
  input  wire logic [3:0]  hs_overcurrent,
  input  wire logic [3:0]  hs_overtemp,
  input  wire logic        supply_undervolt,
  input  wire logic        supply_overvolt,
  output logic      [3:0]  high_side_output,
  output logic             int_req,
  output logic             wake_req,
  output logic      [2:0]  pin_static
);
  logic [5:0]  setup_r [2];
  logic [5:0]  setup_nxt [2];
  logic [1:0]  restart_r, restart_nxt;
  logic [1:0]  map_r [4];
  logic [1:0]  map_nxt [4];
  logic [7:0]  wen_r, wen_nxt;
  logic [2:0]  wstat_a_r, wstat_a_nxt;
  logic [1:0]  wstat_b_r, wstat_b_nxt;
  logic [2:0]  lvl_r, lvl_nxt;
  logic        cmd_err_r, cmd_err_nxt;
  logic [1:0]  uvov_en_r, uvov_en_nxt;
  logic [3:0]  hs_off_r, hs_off_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic [3:0]  hs_r, hs_nxt;
  logic        int_r, int_nxt;
  logic        wake_r, wake_nxt;
  logic [2:0]  static_r, static_nxt;
  logic [1:0]  t_act, t_start, t_end, t_first, t_run, t_idle_hi;
  logic [2:0]  s_valid, s_level, s_change, s_armed, s_tsel;
  logic [3:0]  fault;
  logic        awake;
  logic        low_or_norm;
  logic        fsafe;

  cs_timer_if tif [2] ();

  // Two timers, each with its own setup register
  for (genvar i = 0; i < 2; i++)
  begin : g_tmr
    assign tif[i].period_sel = setup_r[i][cs_pkg::F_PER +: 3];
    assign tif[i].on_sel     = setup_r[i][cs_pkg::F_ON +: 3];
    assign tif[i].restart    = restart_r[i];
    assign t_act[i]          = tif[i].active;
    assign t_start[i]        = tif[i].on_start;
    assign t_end[i]          = tif[i].on_end;
    assign t_first[i]        = tif[i].first;
    assign t_run[i]          = cs_pkg::on_timed(setup_r[i][cs_pkg::F_ON +: 3]);
    assign t_idle_hi[i]      = setup_r[i][cs_pkg::F_ON +: 3] == cs_pkg::ON_OFF_HIGH;
    cs_timer #(
      .TICK_CYCLES (TICK_CYCLES)
    ) u_tmr (
      .clk (clk),
      .rst (rst),
      .tl  (tif[i])
    );
  end

  // One filter and reference per wake pin, fed by its selected timer
  for (genvar p = 0; p < 3; p++)
  begin : g_smp
    assign s_tsel[p]  = wen_r[cs_pkg::F_TSEL + p];
    assign s_armed[p] = wen_r[cs_pkg::F_SENSE + p] & t_run[s_tsel[p]] & ~fsafe;
    cs_sampler #(
      .FILT_CYCLES (FILT_CYCLES)
    ) u_smp (
      .clk    (clk),
      .rst    (rst),
      .armed  (s_armed[p]),
      .rearm  (t_start[s_tsel[p]] & t_first[s_tsel[p]]),
      .on_end (t_end[s_tsel[p]]),
      .pin    (wake_input_pin[p]),
      .valid  (s_valid[p]),
      .level  (s_level[p]),
      .change (s_change[p])
    );
  end

  assign fsafe       = (mode == cs_pkg::MODE_FSAFE);
  assign awake       = (mode == cs_pkg::MODE_NORMAL) || (mode == cs_pkg::MODE_STOP);
  assign low_or_norm = !fsafe;

  // Faults that switch an output off; voltage faults only when enabled
  assign fault = (hs_overcurrent | hs_overtemp
                 | {4{supply_undervolt & uvov_en_r[0]}}
                 | {4{supply_overvolt & uvov_en_r[1]}}) & {4{low_or_norm}};

  // Register writes; hardware sets win over same-cycle software clears
  always_comb
  begin
    setup_nxt   = setup_r;
    map_nxt     = map_r;
    wen_nxt     = wen_r;
    uvov_en_nxt = uvov_en_r;
    restart_nxt = 2'b00;
    cmd_err_nxt = cmd_err_r;
    wstat_a_nxt = wstat_a_r;
    wstat_b_nxt = wstat_b_r;
    hs_off_nxt  = hs_off_r;
    if (wr)
    begin
      case (addr)
        cs_pkg::REG_T1_SETUP, cs_pkg::REG_T2_SETUP:
        begin
          setup_nxt[addr[0]]   = wdata[5:0];
          restart_nxt[addr[0]] = 1'b1;
          if (cs_pkg::on_ticks(wdata[cs_pkg::F_ON +: 3]) > cs_pkg::period_ticks(wdata[cs_pkg::F_PER +: 3]))
            cmd_err_nxt = 1'b1;
        end
        cs_pkg::REG_HS_A, cs_pkg::REG_HS_B:
        begin
          // Rewriting the mapping re-arms outputs that a fault switched off
          map_nxt[{addr[0], 1'b0}] = wdata[1:0];
          map_nxt[{addr[0], 1'b1}] = wdata[3:2];
          hs_off_nxt[{addr[0], 1'b0}] = 1'b0;
          hs_off_nxt[{addr[0], 1'b1}] = 1'b0;
        end
        cs_pkg::REG_WAKE_EN:
          wen_nxt = wdata[7:0];
        cs_pkg::REG_WSTAT_A:
          wstat_a_nxt = wstat_a_r & ~wdata[2:0];
        cs_pkg::REG_WSTAT_B:
          wstat_b_nxt = wstat_b_r & ~wdata[1:0];
        cs_pkg::REG_FAULT:
        begin
          if (wdata[cs_pkg::F_CMDERR])
            cmd_err_nxt = 1'b0;
          uvov_en_nxt = wdata[cs_pkg::F_UVEN +: 2];
        end
        default:
          cmd_err_nxt = cmd_err_r;
      endcase
    end
    // Sensed level changes set the pin flag in any mode but fail-safe
    wstat_a_nxt = wstat_a_nxt | (s_change & {3{low_or_norm}});
    // Cyclic wake: every on-time start but the first
    wstat_b_nxt = wstat_b_nxt | (t_start & ~t_first & wen_r[cs_pkg::F_TWAKE +: 2] & {2{awake}});
    // Fault switch-off only gates the output; the timer is left running
    hs_off_nxt  = hs_off_nxt | fault;
  end

  // Level status follows sampled levels for sensed pins, raw levels otherwise
  always_comb
  begin
    lvl_nxt = lvl_r;
    if (awake)
    begin
      for (int p = 0; p < 3; p++)
      begin
        if (s_armed[p])
        begin
          if (s_valid[p])
            lvl_nxt[p] = s_level[p];
        end
        else
          lvl_nxt[p] = wake_input_pin[p];
      end
    end
  end

  // Outputs: high-side enables, interrupt pulse, wake request, static sensing
  always_comb
  begin
    for (int h = 0; h < 4; h++)
    begin
      case (map_r[h])
        cs_pkg::HS_ON:
          hs_nxt[h] = 1'b1;
        cs_pkg::HS_T1, cs_pkg::HS_T2:
          // Idle level holds until the timer runs; a start from off-high drops the output for one cycle
          hs_nxt[h] = t_run[map_r[h][0]] ? t_act[map_r[h][0]] : t_idle_hi[map_r[h][0]];
        default:
          hs_nxt[h] = 1'b0;
      endcase
    end
    hs_nxt     = hs_nxt & ~hs_off_r & ~fault & {4{~fsafe}};
    // Pin and timer events reach the interrupt only in Normal and Stop
    int_nxt    = awake && ((|s_change)
                 || (|(t_start & ~t_first & wen_r[cs_pkg::F_TWAKE +: 2])));
    // In Sleep any pending flag, old or new, asks for the regulator at once
    wake_nxt   = (mode == cs_pkg::MODE_SLEEP) && ((|wstat_a_r) || (|wstat_b_r) || (|s_change));
    static_nxt = fsafe ? 3'b111 : ~wen_r[cs_pkg::F_SENSE +: 3];
  end

  // Read mux; data stand in the cycle after the strobe only
  always_comb
  begin
    rdata_nxt = 16'h0000;
    if (rd)
    begin
      case (addr)
        cs_pkg::REG_T1_SETUP, cs_pkg::REG_T2_SETUP:
          rdata_nxt = {10'h000, setup_r[addr[0]]};
        cs_pkg::REG_HS_A, cs_pkg::REG_HS_B:
          rdata_nxt = {12'h000, map_r[{addr[0], 1'b1}], map_r[{addr[0], 1'b0}]};
        cs_pkg::REG_WAKE_EN:
          rdata_nxt = {8'h00, wen_r};
        cs_pkg::REG_WSTAT_A:
          rdata_nxt = {13'h0000, wstat_a_r};
        cs_pkg::REG_WSTAT_B:
          rdata_nxt = {14'h0000, wstat_b_r};
        cs_pkg::REG_LVL:
          rdata_nxt = {13'h0000, lvl_r};
        cs_pkg::REG_FAULT:
          rdata_nxt = {8'h00, hs_off_r, 1'b0, uvov_en_r, cmd_err_r};
        default:
          rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      setup_r[0] <= cs_pkg::RST_SETUP;
      setup_r[1] <= cs_pkg::RST_SETUP;
      for (int h = 0; h < 4; h++)
        map_r[h] <= cs_pkg::HS_OFF;
      restart_r <= 2'b00;
      wen_r     <= cs_pkg::RST_WEN;
      uvov_en_r <= 2'b00;
      cmd_err_r <= 1'b0;
      wstat_a_r <= 3'h0;
      wstat_b_r <= 2'h0;
      hs_off_r  <= cs_pkg::RST_HS;
      lvl_r     <= 3'h0;
      rdata_r   <= 16'h0000;
      hs_r      <= cs_pkg::RST_HS;
      int_r     <= 1'b0;
      wake_r    <= 1'b0;
      static_r  <= 3'h7;
    end
    else
    begin
      setup_r   <= setup_nxt;
      map_r     <= map_nxt;
      restart_r <= restart_nxt;
      wen_r     <= wen_nxt;
      uvov_en_r <= uvov_en_nxt;
      cmd_err_r <= cmd_err_nxt;
      wstat_a_r <= wstat_a_nxt;
      wstat_b_r <= wstat_b_nxt;
      hs_off_r  <= hs_off_nxt;
      lvl_r     <= lvl_nxt;
      rdata_r   <= rdata_nxt;
      hs_r      <= hs_nxt;
      int_r     <= int_nxt;
      wake_r    <= wake_nxt;
      static_r  <= static_nxt;
    end
  end

  assign rdata            = rdata_r;
  assign high_side_output = hs_r;
  assign int_req          = int_r;
  assign wake_req         = wake_r;
  assign pin_static       = static_r;
endmodule
`default_nettype wire

// ---- sim/wake_switch_model.sv ----
`default_nettype none
// External switch sensed through a high-side supply; the input
// capacitor keeps the last level while the supply is off
module wake_switch_model (
  input  wire logic clk,
  input  wire logic supply,
  input  wire logic closed,
  output logic      pin = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // Level only refreshes while powered, like the real RC front end
  always @(posedge clk)
  begin
    if (supply)
      pin <= closed;
  end
endmodule
`default_nettype wire

// ---- sim/cs_assertions.sv ----
`default_nettype none
module cs_assertions (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  input wire logic [1:0]  mode,
  input wire logic [3:0]  hs_overcurrent,
  input wire logic [3:0]  hs_overtemp,
  input wire logic [3:0]  high_side_output,
  input wire logic        int_req,
  input wire logic        wake_req,
  input wire logic [2:0]  pin_static
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Read answer, then idle
  sequence s_rd_done;
    rd ##1 !rd;
  endsequence
  sequence s_fsafe;
    mode == cs_pkg::MODE_FSAFE;
  endsequence
  AST_RD_STANDS: assert property (s_rd_done |=> rdata == 16'h0000)
    else $error("read data held too long");
  AST_WR_QUIET: assert property (wr |=> rdata == 16'h0000)
    else $error("read data after a write");
  AST_FS_OUT: assert property (s_fsafe |=> high_side_output == 4'h0)
    else $error("output on in fail-safe");
  AST_FS_STATIC: assert property (s_fsafe |=> pin_static == 3'h7)
    else $error("pins not static in fail-safe");
  AST_FAULT_OFF: assert property ((|(hs_overcurrent | hs_overtemp))
    |=> (high_side_output & $past(hs_overcurrent | hs_overtemp)) == 4'h0)
    else $error("faulted output still on");
  AST_INT_PULSE: assert property (int_req |=> !int_req)
    else $error("interrupt longer than one cycle");
  AST_INT_MODE: assert property (int_req
    |-> $past(mode) == cs_pkg::MODE_NORMAL || $past(mode) == cs_pkg::MODE_STOP)
    else $error("interrupt outside normal or stop");
  AST_WAKE_SLEEP: assert property (wake_req |-> $past(mode) == cs_pkg::MODE_SLEEP)
    else $error("power-up request outside sleep");
endmodule
bind cyclic_sense_wake_timers cs_assertions chk_u (.clk(clk), .rst(rst), .wr(wr), .rd(rd),
  .rdata(rdata), .mode(mode), .hs_overcurrent(hs_overcurrent), .hs_overtemp(hs_overtemp),
  .high_side_output(high_side_output), .int_req(int_req), .wake_req(wake_req),
  .pin_static(pin_static));
`default_nettype wire

// ---- sim/tb_top.sv ----
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TK = 4;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] rdata;
  logic [1:0]  mode = 2'h0;
  logic [3:0]  oc = 4'h0;
  logic [3:0]  ot = 4'h0;
  logic        uv = 1'b0;
  logic        ov = 1'b0;
  logic [3:0]  hs;
  logic        irq;
  logic        wreq;
  logic [2:0]  pstat;
  logic        sw = 1'b0;
  logic        sw_pin;
  logic [15:0] v;
  int          c;
  int          err_total = 0;
  int          num_checks = 0;

  // Short tick and filter keep the long periods affordable
  cyclic_sense_wake_timers #(.TICK_CYCLES(TK), .FILT_CYCLES(8)) dut_u (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .mode(mode), .wake_input_pin({2'h0, sw_pin}), .hs_overcurrent(oc), .hs_overtemp(ot),
    .supply_undervolt(uv), .supply_overvolt(ov), .high_side_output(hs),
    .int_req(irq), .wake_req(wreq), .pin_static(pstat));
  wake_switch_model sw_u (.clk(clk), .supply(hs[0]), .closed(sw), .pin(sw_pin));

  initial
  begin
    forever #25 clk = ~clk;
  end

  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
  endtask

  // Bus cycles: strobe for one cycle, data stands the cycle after
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
    num_checks++;
    if (v !== e)
      $display("[ERR] %0t reg %h got %h exp %h", $time, a, v, e);
    if (v !== e)
      err_total++;
  endtask

  task automatic chk_val(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e)
      $display("[ERR] %0t port got %h exp %h", $time, g, e);
    if (g !== e)
      err_total++;
  endtask

  // Interrupt pulses seen over n cycles
  task automatic cnt_int(input int n);
    c = 0;
    repeat (n)
    begin
      @(posedge clk);
      #1;
      if (irq === 1'b1)
        c++;
    end
  endtask

  task automatic wait_hs(input logic lvl);
    c = 0;
    while (hs[0] !== lvl && c < 20000)
    begin
      @(posedge clk);
      #1;
      c++;
    end
  endtask

  // Written during off-time so the restart alone starts the on-time
  task automatic meas(input logic [2:0] per, input logic [2:0] on, input int ep, input int eo);
    int t;
    wait_hs(1'b0);
    wr_reg(cs_pkg::REG_T1_SETUP, {10'h000, on, per});
    wait_hs(1'b1);
    wait_hs(1'b0);
    t = c;
    wait_hs(1'b1);
    chk_val(16'(t), 16'(eo));
    chk_val(16'(t + c), 16'(ep));
  endtask

  // Hang guard, well beyond the longest sequence
  initial
  begin
    #2500000;
    err_total++;
    final_report();
  end

  initial
  begin
    do_reset();
    chk_rd(cs_pkg::REG_HS_A, 16'h0000);
    wr_reg(8'h3f, 16'hffff);
    chk_rd(8'h3f, 16'h0000);
    chk_val({13'h0000, pstat}, 16'h0007);
    wr_reg(cs_pkg::REG_T1_SETUP, 16'h0020);
    chk_rd(cs_pkg::REG_FAULT, 16'h0000);
    wr_reg(cs_pkg::REG_T1_SETUP, 16'h0028);
    chk_rd(cs_pkg::REG_FAULT, 16'h0001);
    wr_reg(cs_pkg::REG_FAULT, 16'h0001);
    chk_rd(cs_pkg::REG_FAULT, 16'h0000);
    wr_reg(cs_pkg::REG_HS_A, 16'h0002);
    wr_reg(cs_pkg::REG_T1_SETUP, {10'h000, cs_pkg::ON_OFF_HIGH, 3'h0});
    idle(4);
    chk_val({12'h000, hs}, 16'h0001);
    wr_reg(cs_pkg::REG_T1_SETUP, {10'h000, cs_pkg::ON_OFF_LOW, 3'h0});
    idle(4);
    chk_val({12'h000, hs}, 16'h0000);
    meas(3'h0, 3'h1, 100 * TK, 1 * TK);
    meas(3'h1, 3'h2, 200 * TK, 3 * TK);
    meas(3'h2, 3'h3, 500 * TK, 10 * TK);
    meas(3'h3, 3'h4, 1000 * TK, 100 * TK);
    meas(3'h4, 3'h5, 2000 * TK, 200 * TK);
    // Cyclic sense: reference, change, sleep, fail-safe
    do_reset();
    wr_reg(cs_pkg::REG_HS_A, 16'h0002);
    wr_reg(cs_pkg::REG_WAKE_EN, 16'h0004);
    wr_reg(cs_pkg::REG_T1_SETUP, 16'h0008);
    chk_val({13'h0000, pstat}, 16'h0006);
    cnt_int(200);
    chk_val(16'(c), 16'h0000);
    @(posedge clk);
    sw <= 1'b1;
    cnt_int(420);
    chk_val(16'(c), 16'h0001);
    chk_rd(cs_pkg::REG_WSTAT_A, 16'h0001);
    chk_rd(cs_pkg::REG_LVL, 16'h0001);
    @(posedge clk);
    mode <= cs_pkg::MODE_SLEEP;
    idle(3);
    chk_val({15'h0000, wreq}, 16'h0001);
    wr_reg(cs_pkg::REG_WSTAT_A, 16'h0001);
    idle(3);
    chk_val({15'h0000, wreq}, 16'h0000);
    @(posedge clk);
    sw <= 1'b0;
    cnt_int(420);
    chk_val(16'(c), 16'h0000);
    chk_val({15'h0000, wreq}, 16'h0001);
    @(posedge clk);
    mode <= cs_pkg::MODE_FSAFE;
    idle(3);
    chk_val({9'h000, hs, pstat}, 16'h0007);
    @(posedge clk);
    mode <= cs_pkg::MODE_NORMAL;
    // Cyclic wake with a faulted output on the side
    do_reset();
    wr_reg(cs_pkg::REG_T1_SETUP, 16'h0000);
    wr_reg(cs_pkg::REG_WAKE_EN, 16'h0001);
    wr_reg(cs_pkg::REG_HS_A, 16'h0001);
    wr_reg(cs_pkg::REG_T1_SETUP, 16'h0008);
    cnt_int(380);
    chk_val(16'(c), 16'h0000);
    @(posedge clk);
    oc <= 4'h1;
    idle(2);
    chk_val({12'h000, hs}, 16'h0000);
    cnt_int(400);
    chk_val(16'(c), 16'h0001);
    chk_rd(cs_pkg::REG_WSTAT_B, 16'h0001);
    chk_rd(cs_pkg::REG_FAULT, 16'h0010);
    // Overvoltage stays harmless while only undervoltage switch-off is enabled
    @(posedge clk);
    oc <= 4'h0;
    ov <= 1'b1;
    wr_reg(cs_pkg::REG_FAULT, 16'h0002);
    wr_reg(cs_pkg::REG_HS_A, 16'h0005);
    idle(3);
    chk_val({12'h000, hs}, 16'h0003);
    @(posedge clk);
    ot <= 4'h2;
    idle(2);
    chk_val({12'h000, hs}, 16'h0001);
    @(posedge clk);
    uv <= 1'b1;
    idle(2);
    chk_val({12'h000, hs}, 16'h0000);
    chk_rd(cs_pkg::REG_FAULT, 16'h00f2);
    final_report();
  end
endmodule
`default_nettype wire
